/* File: hdl/step_engine_map.svh */
// Register offsets, field positions, reset values and timing counts of the step engine.
`ifndef STEP_ENGINE_MAP_SVH
`define STEP_ENGINE_MAP_SVH
// ****************************************************************
// Register indices (byte-wide register port)
// ****************************************************************
`define ADDR_STEP_TOTAL_BYTE0 8'h00
`define ADDR_STEP_TOTAL_BYTE1 8'h01
`define ADDR_STEP_TOTAL_BYTE2 8'h02
`define ADDR_STEP_TOTAL_BYTE3 8'h03
`define ADDR_STEP_CTRL        8'h04
`define ADDR_STEP_WM_LO       8'h05
`define ADDR_STEP_WM_HI       8'h06
`define ADDR_AXIS_MAP         8'h07
`define ADDR_ACC_CTRL         8'h08
`define ADDR_ENGINE_HEALTH    8'h09
`define ADDR_PARAM_SEL        8'h0A
`define ADDR_PARAM_LO         8'h0B
`define ADDR_PARAM_HI         8'h0C
// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_EN_COUNTER  0
`define CTRL_EN_DETECTOR 1
`define CTRL_EN_ACTIVITY 2
`define CTRL_CLR_COUNT   3
`define ACC_PERF_MODE    7
`define HEALTH_ODR_50    0
`define HEALTH_ODR_200   1
// ****************************************************************
// Constants
// ****************************************************************
`define WM_FACTOR        16'h0014
`define WM_SLACK_STEPS   4'h9
`define ODR_50HZ_CODE    4'h7
`define ODR_200HZ_CODE   4'h9
`define ACC_CTRL_RESET   8'h08
`define AXIS_MAP_RESET   8'h24
`define FEATURE_RATE_HZ  50
`endif

/* File: hdl/step_engine_pkg.sv */
// Types shared by the step engine.
package step_engine_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_RUN   = 3'b010,
        ST_CLEAR = 3'b100
    } count_state_t;
    typedef logic signed [15:0] param_t;
endpackage : step_engine_pkg

/* File: hdl/step_engine.sv */
// Feature-engine front end: rate check, axis remap, step detector and counter.
`include "step_engine_map.svh"
module step_engine
    import step_engine_pkg::*;
#(
    parameter int NPARAM = 25
) (
    input  wire logic        clock_i,        // 25 MHz clock
    input  wire logic        rst_i,          // Synchronous reset, active high
    input  wire logic        reg_wr_i,       // Register write strobe
    input  wire logic        reg_rd_i,       // Register read strobe
    input  wire logic [7:0]  reg_addr_i,     // Register index
    input  wire logic [7:0]  reg_wdata_i,    // Write data
    input  wire logic [3:0]  odr_code_i,     // Programmed output data rate code
    input  wire logic        tap_en_i,       // Tap feature enabled
    input  wire logic        sample_valid_i, // 50 Hz feature sample strobe
    input  wire logic [11:0] acc_x_i,        // Physical x sample
    input  wire logic [11:0] acc_y_i,        // Physical y sample
    input  wire logic [11:0] acc_z_i,        // Physical z sample
    input  wire logic        step_seen_i,    // Step detected by the core algorithm
    output logic [7:0]       reg_rdata_o,    // Read data, registered
    output logic [11:0]      feat_x_o,       // Remapped feature x
    output logic [11:0]      feat_y_o,       // Remapped feature y
    output logic [11:0]      feat_z_o,       // Remapped feature z
    output logic             feat_valid_o,   // Remapped sample strobe
    output logic             step_irq_o      // Step event pulse
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [31:0]  total_r;
    logic [3:0]   ctrl_r;
    logic [9:0]   wm_level_r;
    logic [7:0]   axis_map_r;
    logic [7:0]   acc_ctrl_r;
    logic [1:0]   health_r;
    logic [4:0]   param_sel_r;
    param_t       param_r [NPARAM];
    param_t       param_live_r [NPARAM];
    logic [15:0]  since_wm_r;
    logic [3:0]   lag_r;
    logic         pend_r;
    count_state_t state_r;
    count_state_t state_nxt;

    // Wrist preset; applied at reset so wrist products need no writes.
    localparam param_t WRIST [25] = '{16'sd301, 16'sd31700, 16'sd315, 16'sd31451, 16'sd4,
        16'sd31551, 16'sd27853, 16'sd1219, 16'sd2437, 16'sd1219, -16'sd6420, 16'sd17932,
        16'sd1, 16'sd39, 16'sd25, 16'sd150, 16'sd160, 16'sd1, 16'sd12, 16'sd15600,
        16'sd256, 16'sd1, 16'sd3, 16'sd1, 16'sd14};

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire        wr_ctrl   = reg_wr_i && reg_addr_i == `ADDR_STEP_CTRL;
    wire        cnt_en    = ctrl_r[`CTRL_EN_COUNTER];
    wire        det_en    = ctrl_r[`CTRL_EN_DETECTOR];
    wire        any_en    = |ctrl_r[2:0];
    wire        clr_req   = ctrl_r[`CTRL_CLR_COUNT] && cnt_en;
    wire        low_power = !acc_ctrl_r[`ACC_PERF_MODE];
    wire [15:0] wm_steps  = 16'(wm_level_r * `WM_FACTOR);
    wire        wm_on     = wm_level_r != 10'h000;
    wire        wm_hit    = wm_on && cnt_en && since_wm_r >= wm_steps;
    wire        step_cnt  = step_seen_i && cnt_en && state_r == ST_RUN;
    // A report may retire in the cycle that counts a step, so both are kept.
    wire        wm_release = pend_r && (lag_r == 4'h0 || !step_seen_i);
    wire [15:0] since_step = step_cnt ? since_wm_r + 16'h0001 : since_wm_r;
    wire        param_ok   = param_sel_r < 5'(NPARAM);
    wire [1:0]  health_now = {low_power && tap_en_i && odr_code_i < `ODR_200HZ_CODE,
                              low_power && any_en && odr_code_i < `ODR_50HZ_CODE};

    // ****************************************************************
    // Counter state machine
    // ****************************************************************
    always_comb begin
        case (state_r)
            ST_IDLE:  state_nxt = cnt_en ? ST_RUN : ST_IDLE;
            ST_RUN:   state_nxt = !cnt_en ? ST_IDLE : (clr_req ? ST_CLEAR : ST_RUN);
            ST_CLEAR: state_nxt = ST_RUN;
            default:  state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_r  <= ST_IDLE;
            total_r  <= 32'h0000_0000;
            since_wm_r <= 16'h0000;
            lag_r    <= 4'h0;
            pend_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_CLEAR) begin
                total_r    <= 32'h0000_0000;
                since_wm_r <= 16'h0000;
            end else begin
                if (step_cnt) total_r <= total_r + 32'h0000_0001;
                since_wm_r <= wm_release ? since_step - wm_steps : since_step;
            end
            // Steps are drained in small batches, so the watermark report trails
            // the crossing by a bounded number of steps.
            if (state_r == ST_CLEAR || wm_release) begin
                pend_r <= 1'b0;
            end else if (wm_hit && !pend_r) begin
                pend_r <= 1'b1;
                lag_r  <= `WM_SLACK_STEPS;
            end else if (pend_r && step_cnt && lag_r != 4'h0) begin
                lag_r <= lag_r - 4'h1;
            end
        end
    end

    // ****************************************************************
    // Control registers and parameters
    // ****************************************************************
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ctrl_r      <= 4'h0;
            wm_level_r  <= 10'h000;
            axis_map_r  <= `AXIS_MAP_RESET;
            acc_ctrl_r  <= `ACC_CTRL_RESET;
            health_r    <= 2'b00;
            param_sel_r <= 5'h00;
        end else begin
            health_r <= health_now;
            if (wr_ctrl) begin
                ctrl_r <= reg_wdata_i[3:0];
            end else if (state_r == ST_CLEAR || !cnt_en) begin
                ctrl_r[`CTRL_CLR_COUNT] <= 1'b0;
            end
            if (reg_wr_i && reg_addr_i == `ADDR_STEP_WM_LO) wm_level_r[7:0] <= reg_wdata_i;
            if (reg_wr_i && reg_addr_i == `ADDR_STEP_WM_HI) wm_level_r[9:8] <= reg_wdata_i[1:0];
            if (reg_wr_i && reg_addr_i == `ADDR_AXIS_MAP)   axis_map_r <= reg_wdata_i;
            if (reg_wr_i && reg_addr_i == `ADDR_ACC_CTRL)   acc_ctrl_r <= reg_wdata_i;
            if (reg_wr_i && reg_addr_i == `ADDR_PARAM_SEL)  param_sel_r <= reg_wdata_i[4:0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NPARAM; gi++) begin : g_param
            wire sel = param_sel_r == 5'(gi);
            always_ff @(posedge clock_i) begin
                if (rst_i) begin
                    param_r[gi]      <= WRIST[gi];
                    param_live_r[gi] <= WRIST[gi];
                end else begin
                    if (reg_wr_i && sel && reg_addr_i == `ADDR_PARAM_LO)
                        param_r[gi][7:0] <= reg_wdata_i;
                    if (reg_wr_i && sel && reg_addr_i == `ADDR_PARAM_HI)
                        param_r[gi][15:8] <= reg_wdata_i;
                    if (!any_en)
                        param_live_r[gi] <= param_r[gi];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Axis remap (feature path only; raw inputs are untouched)
    // ****************************************************************
    function automatic logic [11:0] pick(input logic [1:0] s, input logic inv);
        logic [11:0] v;
        v = (s == 2'd1) ? acc_y_i : (s == 2'd2) ? acc_z_i : acc_x_i;
        pick = inv ? 12'(-v) : v;
    endfunction : pick

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            feat_x_o     <= 12'h000;
            feat_y_o     <= 12'h000;
            feat_z_o     <= 12'h000;
            feat_valid_o <= 1'b0;
            step_irq_o   <= 1'b0;
            reg_rdata_o  <= 8'h00;
        end else begin
            feat_valid_o <= sample_valid_i;
            if (sample_valid_i) begin
                feat_x_o <= pick(axis_map_r[1:0], axis_map_r[2]);
                feat_y_o <= pick(axis_map_r[4:3], axis_map_r[5]);
                feat_z_o <= pick(axis_map_r[7:6], acc_ctrl_r[0]);
            end
            // Exactly one source drives the step interrupt.
            step_irq_o <= wm_on ? wm_release
                                : (det_en && step_seen_i);
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `ADDR_STEP_TOTAL_BYTE0: reg_rdata_o <= total_r[7:0];
                    `ADDR_STEP_TOTAL_BYTE1: reg_rdata_o <= total_r[15:8];
                    `ADDR_STEP_TOTAL_BYTE2: reg_rdata_o <= total_r[23:16];
                    `ADDR_STEP_TOTAL_BYTE3: reg_rdata_o <= total_r[31:24];
                    `ADDR_STEP_CTRL:        reg_rdata_o <= {4'h0, ctrl_r};
                    `ADDR_STEP_WM_LO:       reg_rdata_o <= wm_level_r[7:0];
                    `ADDR_STEP_WM_HI:       reg_rdata_o <= {6'h00, wm_level_r[9:8]};
                    `ADDR_AXIS_MAP:         reg_rdata_o <= axis_map_r;
                    `ADDR_ACC_CTRL:         reg_rdata_o <= acc_ctrl_r;
                    `ADDR_ENGINE_HEALTH:    reg_rdata_o <= {6'h00, health_r};
                    `ADDR_PARAM_SEL:        reg_rdata_o <= {3'h0, param_sel_r};
                    `ADDR_PARAM_LO:         reg_rdata_o <= param_ok ? param_r[param_sel_r][7:0]
                                                                    : 8'h00;
                    `ADDR_PARAM_HI:         reg_rdata_o <= param_ok ? param_r[param_sel_r][15:8]
                                                                    : 8'h00;
                    default:                reg_rdata_o <= 8'h00;
                endcase
            end
        end
    end
endmodule : step_engine

/* File: test/step_engine_monitor.sv */
// Checker that watches the step engine ports.
module step_engine_monitor (
    input wire logic       clock_i,        // Clock
    input wire logic       rst_i,          // Reset
    input wire logic       reg_wr_i,       // Write strobe
    input wire logic       reg_rd_i,       // Read strobe
    input wire logic [7:0] reg_addr_i,     // Index
    input wire logic [7:0] reg_wdata_i,    // Write data
    input wire logic [3:0] odr_code_i,     // Rate code
    input wire logic       tap_en_i,       // Tap in use
    input wire logic       sample_valid_i, // Sample strobe
    input wire logic       step_seen_i,    // Step pulse
    input wire logic [7:0] reg_rdata_o,    // Read data
    input wire logic       feat_valid_o,   // Feature strobe
    input wire logic       step_irq_o      // Step event
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Shadow of host writes
    // ****************************************************************
    logic [7:0] map_r;
    logic [2:0] ctrl_r;
    logic       perf_r;
    logic [9:0] wm_r;
    logic [9:0] wm_q;
    logic [1:0] hl_q;
    wire  [1:0] hl = {!perf_r && tap_en_i && odr_code_i < 4'h9,
                      !perf_r && |ctrl_r && odr_code_i < 4'h7};
    wire        rd9 = reg_rd_i && reg_addr_i == 8'h09;
    always_ff @(posedge clock_i) begin
        hl_q <= hl;
        wm_q <= wm_r;
        if (rst_i) begin
            map_r  <= 8'h24;
            ctrl_r <= 3'h0;
            perf_r <= 1'b0;
            wm_r   <= 10'h000;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                8'h04: ctrl_r <= reg_wdata_i[2:0];
                8'h05: wm_r[7:0] <= reg_wdata_i;
                8'h06: wm_r[9:8] <= reg_wdata_i[1:0];
                8'h07: map_r <= reg_wdata_i;
                8'h08: perf_r <= reg_wdata_i[7];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    property p_fv; sample_valid_i |=> feat_valid_o; endproperty
    a_fv: assert property (p_fv) else $error("feature strobe missing");
    property p_fv_idle; !sample_valid_i |=> !feat_valid_o; endproperty
    a_fv_idle: assert property (p_fv_idle) else $error("feature strobe without sample");
    property p_health; rd9 && hl == hl_q |=> reg_rdata_o[1:0] == $past(hl); endproperty
    a_health: assert property (p_health) else $error("health flags wrong");
    property p_perf; rd9 && perf_r && hl_q == 2'b00 |=> reg_rdata_o[1:0] == 2'b00; endproperty
    a_perf: assert property (p_perf) else $error("health flag in continuous mode");
    property p_map; reg_rd_i && reg_addr_i == 8'h07 |=> reg_rdata_o == $past(map_r); endproperty
    a_map: assert property (p_map) else $error("axis map read back wrong");
    property p_det; step_seen_i && ctrl_r[1] && wm_r == 10'h000 |=> step_irq_o; endproperty
    a_det: assert property (p_det) else $error("per-step event missing");
    property p_det_only; step_irq_o && wm_r == 10'h000 && wm_q == 10'h000 |-> $past(step_seen_i);
    endproperty
    a_det_only: assert property (p_det_only) else $error("step event without a step");
endmodule : step_engine_monitor
bind step_engine step_engine_monitor step_engine_monitor_i (.*);

/* File: test/host_model.sv */
// Host that programs and polls the step engine over its register port.
module host_model (
    input  wire logic       clock_i,     // Clock
    input  wire logic [7:0] reg_rdata_i, // Read data
    output logic            reg_wr_o,    // Write strobe
    output logic            reg_rd_o,    // Read strobe
    output logic [7:0]      reg_addr_o,  // Index
    output logic [7:0]      reg_wdata_o, // Write data
    output logic [3:0]      odr_code_o,  // Rate code
    output logic            tap_en_o     // Tap in use
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
        odr_code_o  = 4'h7;
        tap_en_o    = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_wr_o    <= 1'b1;
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        @(posedge clock_i);
        reg_wr_o    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        reg_rd_o   <= 1'b1;
        reg_addr_o <= a;
        @(posedge clock_i);
        reg_rd_o   <= 1'b0;
        @(posedge clock_i);
        #1 d = reg_rdata_i;
    endtask : rd
    // Rates below the minimum are only set when the health flags are under test.
    task automatic set_rate(input logic [3:0] r, input logic t);
        @(posedge clock_i);
        odr_code_o <= r;
        tap_en_o   <= t;
    endtask : set_rate
endmodule : host_model

/* File: test/step_engine_bench.sv */
// Self-checking bench for the step engine.
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module step_engine_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i, rst_i, reg_wr_i, reg_rd_i, tap_en_i, sample_valid_i, step_seen_i;
    logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic [3:0]  odr_code_i;
    logic [11:0] acc_x_i, acc_y_i, acc_z_i, feat_x_o, feat_y_o, feat_z_o;
    logic        feat_valid_o, step_irq_o;
    int          cmp_count, miscompares, irqs;
    step_engine step_engine_i (.*);
    host_model host_model_i (.clock_i(clock_i), .reg_rdata_i(reg_rdata_o),
        .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i),
        .reg_wdata_o(reg_wdata_i), .odr_code_o(odr_code_i), .tap_en_o(tap_en_i));
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    always @(posedge clock_i) if (step_irq_o === 1'b1) irqs <= irqs + 1;
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host_model_i.rd(a, d);
        `CHK(d, e)
    endtask : rd_chk
    task automatic steps(input int n);
        repeat (2) @(posedge clock_i);
        repeat (n) begin
            step_seen_i <= 1'b1;
            @(posedge clock_i);
            step_seen_i <= 1'b0;
            repeat (2) @(posedge clock_i);
        end
    endtask : steps
    task automatic t_reset();
        rd_chk(8'h07, 8'h24);
        for (int i = 0; i < 4; i++) rd_chk(8'(i), 8'h00);
    endtask : t_reset
    task automatic t_remap();
        host_model_i.wr(8'h07, 8'h15);
        host_model_i.wr(8'h08, 8'h01);
        sample_valid_i <= 1'b1;
        @(posedge clock_i);
        sample_valid_i <= 1'b0;
        #1 `CHK(feat_valid_o, 1'b1)
        `CHK(feat_x_o, 12'h000 - acc_y_i)
        `CHK(feat_y_o, acc_z_i)
        `CHK(feat_z_o, 12'h000 - acc_x_i)
    endtask : t_remap
    task automatic t_count();
        host_model_i.wr(8'h04, 8'h01);
        steps(300);
        for (int i = 0; i < 4; i++) rd_chk(8'(i), 8'(32'd300 >> (8 * i)));
        host_model_i.wr(8'h04, 8'h00);
        host_model_i.wr(8'h04, 8'h08);
        rd_chk(8'h00, 8'h2C);
        host_model_i.wr(8'h04, 8'h09);
        repeat (3) @(posedge clock_i);
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h04, 8'h01);
        steps(2);
        rd_chk(8'h00, 8'h02);
    endtask : t_count
    task automatic t_det();
        int base;
        host_model_i.wr(8'h04, 8'h02);
        base = irqs;
        steps(5);
        `CHK(irqs - base, 5)
    endtask : t_det
    task automatic t_wm();
        int base;
        host_model_i.wr(8'h04, 8'h00);
        host_model_i.wr(8'h05, 8'h01);
        host_model_i.wr(8'h04, 8'h0B);
        // Counting restarts only once the clear has gone through.
        repeat (3) @(posedge clock_i);
        base = irqs;
        steps(19);
        `CHK(irqs - base, 0)
        steps(11);
        `CHK(irqs - base, 1)
        steps(10);
        repeat (12) @(posedge clock_i);
        `CHK(irqs - base, 2)
    endtask : t_wm
    task automatic t_health();
        logic [15:0] hv [4] = '{16'h0051, 16'h0172, 16'h0190, 16'h8110};
        for (int i = 0; i < 4; i++) begin
            host_model_i.wr(8'h08, {hv[i][15], 7'h00});
            host_model_i.set_rate(hv[i][7:4], hv[i][8]);
            repeat (2) @(posedge clock_i);
            rd_chk(8'h09, {6'h00, hv[i][1:0]});
        end
    endtask : t_health
    task automatic t_param();
        host_model_i.wr(8'h04, 8'h00);
        host_model_i.wr(8'h0A, 8'h0A);
        rd_chk(8'h0B, 8'hEC);
        rd_chk(8'h0C, 8'hE6);
        host_model_i.wr(8'h0A, 8'h00);
        rd_chk(8'h0B, 8'h2D);
        host_model_i.wr(8'h0B, 8'h32);
        host_model_i.wr(8'h0C, 8'h01);
        rd_chk(8'h0B, 8'h32);
        rd_chk(8'h0C, 8'h01);
        host_model_i.wr(8'h04, 8'h03);
        rd_chk(8'h04, 8'h03);
    endtask : t_param
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (20000) @(posedge clock_i);
        miscompares++;
        final_report();
    end
    initial begin
        {rst_i, sample_valid_i, step_seen_i, irqs} = {3'b100, 32'd0};
        {acc_x_i, acc_y_i, acc_z_i} = {12'h123, 12'h456, 12'h789};
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        t_reset();
        t_remap();
        t_count();
        t_det();
        t_wm();
        t_health();
        t_param();
        final_report();
    end
endmodule : step_engine_bench
